// file: inc/rmcsr_pkg.sv
// Register map, field layout and timing constants of the radio core
package rmcsr_pkg;
   // Frame layout
   localparam int FRAME_BITS    = 16;              // Bits in one serial word
   localparam int ADDR_BITS     = 4;               // Address field width
   localparam int DATA_BITS     = 12;              // Data field width
   localparam int ADDR_MSB      = 15;              // Address field top bit
   localparam int ADDR_LSB      = 12;              // Address field low bit
   // Register addresses
   localparam logic [3:0] ADDR_BLOCK_EN = 4'h1;    // circuit_block_enables
   localparam logic [3:0] ADDR_SYNTHESIZER_SETTINGS    = 4'h2;    // synthesizer_settings
   localparam logic [3:0] ADDR_CHANNEL  = 4'h3;    // channel_select
   localparam logic [3:0] ADDR_RECEIVE  = 4'h4;    // receiver_settings
   localparam logic [3:0] ADDR_TRANSMIT = 4'h5;    // transmitter_settings
   // Power-up defaults
   localparam logic [11:0] RST_BLOCK_EN = 12'h01e;
   localparam logic [11:0] RST_SYNTHESIZER_SETTINGS    = 12'h040;
   localparam logic [11:0] RST_CHANNEL  = 12'h025;
   localparam logic [11:0] RST_RECEIVE  = 12'hfd2;
   localparam logic [11:0] RST_TRANSMIT = 12'h02d;
   // Block-enable bit positions
   localparam int BIT_AMP_BIAS  = 10;
   localparam int BIT_TX_FILTER = 9;
   localparam int BIT_TX_UPCONV = 8;
   localparam int BIT_RX_DOWN   = 6;
   localparam int BIT_RX_LNA    = 5;
   localparam int BIT_AUTOTUNE  = 4;
   localparam int BIT_CHG_PUMP  = 3;
   localparam int BIT_SYNTHESIZER_SETTINGS_LP  = 2;
   localparam int BIT_OSC       = 1;
   // Field positions
   localparam int CHAN_MSB      = 6;               // channel_number 6:0
   localparam int BW_MSB        = 2;               // filter_corner_select 2:0
   localparam int DL_LSB        = 4;               // detector_midlevel 5:4
   localparam int DL_MSB        = 5;
   localparam int PA_MSB        = 3;               // Output stage bias 3:0
   localparam int DRV_LSB       = 4;               // Predriver bias 5:4
   localparam int DRV_MSB       = 5;
   localparam int BIT_DETECT    = 6;               // power_sensor_switch
   // Readiness timing
   localparam real SYS_CLK_MHZ  = 100.0;
   localparam real RX_READY_US  = 10.0;
   localparam real TX_CAL_US    = 2.2;
   localparam real TX_READY_US  = 5.0;
   // Rounded, not ceiled: 2.2 times 100.0 lands a hair above 220 in
   // floating point and a ceiling would add a spurious cycle
   localparam int  RX_READY_CYC = int'(RX_READY_US * SYS_CLK_MHZ);
   localparam int  TX_CAL_CYC   = int'(TX_CAL_US * SYS_CLK_MHZ);
   localparam int  TX_READY_CYC = int'(TX_READY_US * SYS_CLK_MHZ);
   localparam int  CNT_BITS     = 11;              // Holds the longest count

   // Operating modes
   typedef enum logic [2:0] {
      RMCSR_SHUTDOWN = 3'b000,
      RMCSR_STANDBY  = 3'b001,
      RMCSR_RECEIVE  = 3'b010,
      RMCSR_TRANSMIT = 3'b011,
      RMCSR_ILLEGAL  = 3'b100
   } rmcsr_mode_t;

   // Per-block enables
   typedef struct packed {
      logic amp_bias_ctrl_on;
      logic tx_filter_on;
      logic tx_upconv_chain_on;
      logic rx_downconv_chain_on;
      logic rx_low_noise_amp_on;
      logic autotune_on;
      logic charge_pump_on;
      logic synthesizer_settings_loop_on;
      logic oscillator_on;
   } rmcsr_enables_t;

   // Decoded settings fields
   typedef struct packed {
      logic [6:0]  channel_number;
      logic [2:0]  filter_corner_select;
      logic [1:0]  detector_midlevel;
      logic [3:0]  output_bias;
      logic [1:0]  predriver_bias;
      logic        power_sensor_switch;
      logic [11:0] synthesizer_settings;
      logic [11:0] receiver_settings;
   } rmcsr_settings_t;
endpackage

// file: logic/rmcsr_core.sv
// Mode decode, serial register port and block enables of the radio core
// Contract
// - Shutdown low powers down all but serial
// - Registers persist and load during shutdown
// - Standby keeps synthesizer_settings, oscillator, autotuner on; here they follow their enable bits (set by default)
// - Serial loads accepted in any mode
// - Receive mode; ready about 10us later
// - Transmit mode; calibration then ready 5us
// - Word is 4 address, 12 data bits
// - Shift MSB first on clock rise
// - Frame end latches addressed register
// - Keep last 16 bits, no count check
// - Defaults load at supply power-up
// - Five registers at addresses 1 to 5
// - Channel 0..99, default 37
// - Transmit blocks: bit or transmit input
// - Receive blocks: bit or receive input
// - Autotuner: bit, receive or transmit
// - Loop blocks follow their bit only
// - Transmit settings bias and detector fields
// - Filter corner defaults to code 010
`timescale 1ns/1ps

module rmcsr_core #(
   parameter int RX_READY_CYCLES = rmcsr_pkg::RX_READY_CYC,
   parameter int TX_CAL_CYCLES   = rmcsr_pkg::TX_CAL_CYC,
   parameter int TX_READY_CYCLES = rmcsr_pkg::TX_READY_CYC
) (
   input  wire logic                       sys_clk,
   input  wire logic                       reset_n,
   input  wire logic                       power_down_n,
   input  wire logic                       tx_on,
   input  wire logic                       rx_on,
   input  wire logic                       serial_clk,
   input  wire logic                       frame_select_n,
   input  wire logic                       serial_data,
   input  wire logic                       logic_supply_rst_n,
   output rmcsr_pkg::rmcsr_mode_t          op_mode,
   output rmcsr_pkg::rmcsr_enables_t       block_enables,
   output rmcsr_pkg::rmcsr_settings_t      settings,
   output logic                            rx_path_ready,
   output logic                            tx_offset_cal,
   output logic                            tx_path_ready
);

   ////////////////////////////////////////////////////////////////////////
   // Link domain: shifter on the serial clock

   logic [15:0] shift_reg;                         // Last 16 bits seen

   // Shift on each rising edge while framed; no bit count is kept, so a
   // long frame simply keeps its last sixteen bits
   always_ff @(posedge serial_clk) begin
      if (!frame_select_n) begin
         shift_reg <= {shift_reg[14:0], serial_data};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame end crossing into the system domain

   logic [2:0]  sel_sync_reg;                      // Select synchroniser
   logic [15:0] word_reg;                          // Captured frame word
   wire         frame_end;                         // Select rose

   // The serial clock stops outside frames, so the word is held stable in
   // shift_reg once select is high; sampling it after two stages is safe
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sel_sync_reg <= 3'h7;
      end else begin
         sel_sync_reg <= {sel_sync_reg[1:0], frame_select_n};
      end
   end

   assign frame_end = sel_sync_reg[1] & ~sel_sync_reg[2];

   // Capture the stable word one cycle before it is decoded
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         word_reg <= 16'h0000;
      end else if (frame_end) begin
         word_reg <= shift_reg;
      end
   end

   logic load_reg;                                 // Word ready to store

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         load_reg <= 1'b0;
      end else begin
         load_reg <= frame_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file; only supply power-up resets it, not shutdown

   wire [3:0]  word_addr = word_reg[rmcsr_pkg::ADDR_MSB:rmcsr_pkg::ADDR_LSB];
   wire [11:0] word_data = word_reg[rmcsr_pkg::DATA_BITS-1:0];
   wire hit_en  = load_reg && (word_addr == rmcsr_pkg::ADDR_BLOCK_EN);
   wire hit_syn = load_reg && (word_addr == rmcsr_pkg::ADDR_SYNTHESIZER_SETTINGS);
   wire hit_chn = load_reg && (word_addr == rmcsr_pkg::ADDR_CHANNEL);
   wire hit_rx  = load_reg && (word_addr == rmcsr_pkg::ADDR_RECEIVE);
   wire hit_tx  = load_reg && (word_addr == rmcsr_pkg::ADDR_TRANSMIT);

   logic [11:0] block_en_reg;                      // circuit_block_enables
   logic [11:0] synthesizer_settings_reg;                         // synthesizer_settings
   logic [11:0] channel_reg;                       // channel_select
   logic [11:0] receive_reg;                       // receiver_settings
   logic [11:0] transmit_reg;                      // transmitter_settings

   // Writes are taken regardless of the mode pins; other addresses drop.
   // logic_supply_rst_n models the supply ramp from zero
   always_ff @(posedge sys_clk) begin
      if (!logic_supply_rst_n) begin
         block_en_reg <= rmcsr_pkg::RST_BLOCK_EN;
         synthesizer_settings_reg    <= rmcsr_pkg::RST_SYNTHESIZER_SETTINGS;
         channel_reg  <= rmcsr_pkg::RST_CHANNEL;
         receive_reg  <= rmcsr_pkg::RST_RECEIVE;
         transmit_reg <= rmcsr_pkg::RST_TRANSMIT;
      end else begin
         if (hit_en)  block_en_reg <= word_data;
         if (hit_syn) synthesizer_settings_reg    <= word_data;
         if (hit_chn) channel_reg  <= word_data;
         if (hit_rx)  receive_reg  <= word_data;
         if (hit_tx)  transmit_reg <= word_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode pins: two-stage synchronisers

   logic [1:0] pd_sync_reg;                        // power_down_n stages
   logic [1:0] tx_sync_reg;                        // tx_on stages
   logic [1:0] rx_sync_reg;                        // rx_on stages

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pd_sync_reg <= 2'h0;
         tx_sync_reg <= 2'h0;
         rx_sync_reg <= 2'h0;
      end else begin
         pd_sync_reg <= {pd_sync_reg[0], power_down_n};
         tx_sync_reg <= {tx_sync_reg[0], tx_on};
         rx_sync_reg <= {rx_sync_reg[0], rx_on};
      end
   end

   wire run = pd_sync_reg[1];                      // Shutdown inactive
   wire txs = tx_sync_reg[1];
   wire rxs = rx_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   rmcsr_pkg::rmcsr_mode_t mode_next;

   // Both path inputs high is disallowed; it is flagged, not guessed at
   always_comb begin
      mode_next = rmcsr_pkg::RMCSR_SHUTDOWN;
      case ({run, txs, rxs})
         3'b100:  mode_next = rmcsr_pkg::RMCSR_STANDBY;
         3'b101:  mode_next = rmcsr_pkg::RMCSR_RECEIVE;
         3'b110:  mode_next = rmcsr_pkg::RMCSR_TRANSMIT;
         3'b111:  mode_next = rmcsr_pkg::RMCSR_ILLEGAL;
         default: mode_next = rmcsr_pkg::RMCSR_SHUTDOWN;
      endcase
   end

   // Receive path only in receive mode, transmit only in transmit mode
   wire rx_mode = (mode_next == rmcsr_pkg::RMCSR_RECEIVE);
   wire tx_mode = (mode_next == rmcsr_pkg::RMCSR_TRANSMIT);

   ////////////////////////////////////////////////////////////////////////
   // Block enables: shutdown gates every product term

   rmcsr_pkg::rmcsr_enables_t en_next;

   always_comb begin
      en_next = '0;
      en_next.amp_bias_ctrl_on     =
         run & (block_en_reg[rmcsr_pkg::BIT_AMP_BIAS] | tx_mode);
      en_next.tx_filter_on         =
         run & (block_en_reg[rmcsr_pkg::BIT_TX_FILTER] | tx_mode);
      en_next.tx_upconv_chain_on   =
         run & (block_en_reg[rmcsr_pkg::BIT_TX_UPCONV] | tx_mode);
      en_next.rx_downconv_chain_on =
         run & (block_en_reg[rmcsr_pkg::BIT_RX_DOWN] | rx_mode);
      en_next.rx_low_noise_amp_on  =
         run & (block_en_reg[rmcsr_pkg::BIT_RX_LNA] | rx_mode);
      en_next.autotune_on          = run &
         (block_en_reg[rmcsr_pkg::BIT_AUTOTUNE] | rxs | txs);
      en_next.charge_pump_on       =
         run & block_en_reg[rmcsr_pkg::BIT_CHG_PUMP];
      en_next.synthesizer_settings_loop_on        =
         run & block_en_reg[rmcsr_pkg::BIT_SYNTHESIZER_SETTINGS_LP];
      en_next.oscillator_on        =
         run & block_en_reg[rmcsr_pkg::BIT_OSC];
   end

   // Registered so the enables never glitch during a register load
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         op_mode       <= rmcsr_pkg::RMCSR_SHUTDOWN;
         block_enables <= '0;
      end else begin
         op_mode       <= mode_next;
         block_enables <= en_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Readiness timers

   logic [rmcsr_pkg::CNT_BITS-1:0] rx_cnt_reg;     // Cycles in receive
   logic [rmcsr_pkg::CNT_BITS-1:0] tx_cnt_reg;     // Cycles in transmit
   localparam logic [rmcsr_pkg::CNT_BITS-1:0] RX_LIM =
      rmcsr_pkg::CNT_BITS'(RX_READY_CYCLES);
   localparam logic [rmcsr_pkg::CNT_BITS-1:0] TX_CAL =
      rmcsr_pkg::CNT_BITS'(TX_CAL_CYCLES);
   localparam logic [rmcsr_pkg::CNT_BITS-1:0] TX_LIM =
      rmcsr_pkg::CNT_BITS'(TX_READY_CYCLES);

   // Count from the mode entry and saturate; leaving the mode restarts
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !rx_mode) begin
         rx_cnt_reg <= '0;
      end else if (rx_cnt_reg != RX_LIM) begin
         rx_cnt_reg <= rx_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n || !tx_mode) begin
         tx_cnt_reg <= '0;
      end else if (tx_cnt_reg != TX_LIM) begin
         tx_cnt_reg <= tx_cnt_reg + 1'b1;
      end
   end

   // Ready flags are registered for clean data outputs
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rx_path_ready <= 1'b0;
         tx_offset_cal <= 1'b0;
         tx_path_ready <= 1'b0;
      end else begin
         rx_path_ready <= rx_mode && (rx_cnt_reg == RX_LIM);
         tx_offset_cal <= tx_mode && (tx_cnt_reg < TX_CAL);
         tx_path_ready <= tx_mode && (tx_cnt_reg == TX_LIM);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Settings fields; offset-nulling bits are passed as written, since
   // the controller is expected to leave them at default

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         settings <= '0;
      end else begin
         settings.channel_number       <= channel_reg[rmcsr_pkg::CHAN_MSB:0];
         settings.filter_corner_select <= receive_reg[rmcsr_pkg::BW_MSB:0];
         settings.detector_midlevel    <=
            receive_reg[rmcsr_pkg::DL_MSB:rmcsr_pkg::DL_LSB];
         settings.output_bias          <=
            transmit_reg[rmcsr_pkg::PA_MSB:0];
         settings.predriver_bias       <=
            transmit_reg[rmcsr_pkg::DRV_MSB:rmcsr_pkg::DRV_LSB];
         settings.power_sensor_switch  <=
            transmit_reg[rmcsr_pkg::BIT_DETECT];
         settings.synthesizer_settings <= synthesizer_settings_reg;
         settings.receiver_settings    <= receive_reg;
      end
   end

endmodule

// file: dv/rmcsr_monitor.sv
// Port-level checker for the radio control core, bound into the design
`timescale 1ns/1ps
module rmcsr_monitor #(
   parameter int RX_READY_CYCLES = 1000,
   parameter int TX_READY_CYCLES = 500
) (
   input logic                       sys_clk,
   input logic                       reset_n,
   input logic                       power_down_n,
   input logic                       tx_on,
   input logic                       rx_on,
   input logic                       serial_clk,
   input logic                       frame_select_n,
   input logic                       serial_data,
   input logic                       logic_supply_rst_n,
   input rmcsr_pkg::rmcsr_mode_t     op_mode,
   input rmcsr_pkg::rmcsr_enables_t  block_enables,
   input rmcsr_pkg::rmcsr_settings_t settings,
   input logic                       rx_path_ready,
   input logic                       tx_offset_cal,
   input logic                       tx_path_ready
);
   logic [15:0] rx_cnt_reg;  // Cycles spent in receive mode
   logic [15:0] tx_cnt_reg;  // Cycles spent in transmit mode
   wire         in_rx;       // Pins ask for receive
   wire         in_tx;       // Pins ask for transmit
   wire         in_stby;     // Pins ask for standby
   wire         in_path;     // Powered with either path pin high
   wire         op_rx;       // Core reports receive
   wire         op_tx;       // Core reports transmit
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   assign in_rx   = power_down_n && rx_on && !tx_on;
   assign in_tx   = power_down_n && tx_on && !rx_on;
   assign in_stby = power_down_n && !tx_on && !rx_on;
   assign in_path = power_down_n && (rx_on || tx_on);
   assign op_rx   = (op_mode == rmcsr_pkg::RMCSR_RECEIVE);
   assign op_tx   = (op_mode == rmcsr_pkg::RMCSR_TRANSMIT);
   ////////////////////////////////////////////////////////////////////////////
   // Dwell counters; reset forces op_mode to shutdown, which clears them
   always_ff @(posedge sys_clk) begin
      rx_cnt_reg <= op_rx ? rx_cnt_reg + 16'h0001 : 16'h0000;
      tx_cnt_reg <= op_tx ? tx_cnt_reg + 16'h0001 : 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Four samples cover the two-stage sync plus the output register
   AST_SHUT_ALL_OFF: assert property ((!power_down_n)[*4] |->
      block_enables == '0 && op_mode == rmcsr_pkg::RMCSR_SHUTDOWN)
      else $error("blocks still on in shutdown");
   AST_TX_BLOCKS_ON: assert property (in_tx[*4] |->
      block_enables[8:6] == 3'h7) else $error("transmit blocks off");
   AST_RX_BLOCKS_ON: assert property (in_rx[*4] |->
      block_enables[5:4] == 2'h3) else $error("receive blocks off");
   AST_TUNER_ON: assert property (in_path[*4] |->
      block_enables.autotune_on) else $error("autotuner off");
   AST_MODE_RX: assert property (in_rx[*4] |-> op_rx)
      else $error("receive mode missing");
   AST_MODE_TX: assert property (in_tx[*4] |-> op_tx)
      else $error("transmit mode missing");
   AST_MODE_STBY: assert property (in_stby[*4] |->
      op_mode == rmcsr_pkg::RMCSR_STANDBY)
      else $error("standby mode missing");
   AST_RX_NOT_EARLY: assert property (
      op_rx && rx_cnt_reg < RX_READY_CYCLES - 1 |-> !rx_path_ready)
      else $error("receive ready too early");
   // Only while transmit is still reported: on leaving, ready drops one
   // edge before this dwell counter clears
   AST_TX_NOT_LATE: assert property (
      op_tx && tx_cnt_reg > TX_READY_CYCLES + 2 |-> tx_path_ready)
      else $error("transmit ready too late");
   AST_CAL_IN_TX: assert property ($rose(tx_offset_cal) |-> op_tx)
      else $error("calibration outside transmit");
   COV_RX_READY: cover property ($rose(rx_path_ready));
   COV_TX_READY: cover property ($rose(tx_path_ready));
   COV_SHUTDOWN: cover property ((!power_down_n)[*4]);
endmodule

bind rmcsr_core rmcsr_monitor #(.RX_READY_CYCLES(RX_READY_CYCLES),
   .TX_READY_CYCLES(TX_READY_CYCLES)) u_rmcsr_monitor (.sys_clk(sys_clk),
   .reset_n(reset_n), .power_down_n(power_down_n), .tx_on(tx_on),
   .rx_on(rx_on), .serial_clk(serial_clk), .frame_select_n(frame_select_n),
   .serial_data(serial_data), .logic_supply_rst_n(logic_supply_rst_n),
   .op_mode(op_mode), .block_enables(block_enables), .settings(settings),
   .rx_path_ready(rx_path_ready), .tx_offset_cal(tx_offset_cal),
   .tx_path_ready(tx_path_ready));

// file: dv/rmcsr_ctrl_model.sv
// Baseband controller model: mode pins and three-wire serial writes
`timescale 1ns/1ps
module rmcsr_ctrl_model (
   input  wire logic sys_clk,
   output logic      power_down_n,
   output logic      tx_on,
   output logic      rx_on,
   output logic      serial_clk,
   output logic      frame_select_n,
   output logic      serial_data
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle: powered, standby, serial clock parked low, frame closed
   initial begin
      power_down_n = 1'b1;
      tx_on = 1'b0;
      rx_on = 1'b0;
      serial_clk = 1'b0;
      frame_select_n = 1'b1;
      serial_data = 1'b1;
   end
   // Mode pins move just after a system edge; callers never ask tx and rx
   task automatic set_pins(input logic pd, input logic tx, input logic rx);
      @(posedge sys_clk);
      #1;
      power_down_n = pd;
      tx_on = tx & ~rx;  // Never both high
      rx_on = rx;
   endtask
   // Frame of n bits, MSB first, captured on rising clock, 30 ns period
   task automatic send_bits(input logic [31:0] v, input int n);
      frame_select_n = 1'b0;
      #7;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data = v[i];
         #15 serial_clk = 1'b1;
         #15 serial_clk = 1'b0;
      end
      #15 frame_select_n = 1'b1;  // Latch edge
      serial_data = ~serial_data;  // Released line must not hold its value
      #120;  // Clock stays quiet well past four system cycles
   endtask
endmodule

// file: dv/rmcsr_core_tb.sv
// Self-checking bench for the radio control core
`timescale 1ns/1ps
module rmcsr_core_tb;
   localparam int RXC = 20;  // Shortened readiness counts
   localparam int TCC = 5;
   localparam int TXC = 10;
   logic                       sys_clk;
   logic                       reset_n;
   logic                       logic_supply_rst_n;
   logic                       power_down_n;
   logic                       tx_on;
   logic                       rx_on;
   logic                       serial_clk;
   logic                       frame_select_n;
   logic                       serial_data;
   rmcsr_pkg::rmcsr_mode_t     op_mode;
   rmcsr_pkg::rmcsr_enables_t  block_enables;
   rmcsr_pkg::rmcsr_settings_t settings;
   rmcsr_pkg::rmcsr_settings_t dflt;  // Power-up field image
   logic                       rx_path_ready;
   logic                       tx_offset_cal;
   logic                       tx_path_ready;
   logic                       cal;
   int                         n;
   int                         err_total;
   int                         samples_checked;
   rmcsr_core #(.RX_READY_CYCLES(RXC), .TX_CAL_CYCLES(TCC),
      .TX_READY_CYCLES(TXC)) u_rmcsr_core (.sys_clk(sys_clk),
      .reset_n(reset_n), .power_down_n(power_down_n), .tx_on(tx_on),
      .rx_on(rx_on), .serial_clk(serial_clk), .frame_select_n(frame_select_n),
      .serial_data(serial_data), .logic_supply_rst_n(logic_supply_rst_n),
      .op_mode(op_mode), .block_enables(block_enables), .settings(settings),
      .rx_path_ready(rx_path_ready), .tx_offset_cal(tx_offset_cal),
      .tx_path_ready(tx_path_ready));
   rmcsr_ctrl_model u_rmcsr_ctrl_model (.sys_clk(sys_clk),
      .power_down_n(power_down_n), .tx_on(tx_on), .rx_on(rx_on),
      .serial_clk(serial_clk), .frame_select_n(frame_select_n),
      .serial_data(serial_data));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   // Full word write; the wait covers sync, capture and output register
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      u_rmcsr_ctrl_model.send_bits({16'h0000, a, d}, 16);
      cyc(8);
   endtask
   task automatic mode(input logic pd, input logic tx, input logic rx);
      u_rmcsr_ctrl_model.set_pins(pd, tx, rx);
      cyc(6);
   endtask
   function automatic rmcsr_pkg::rmcsr_settings_t mk(input logic [11:0] sy,
      input logic [11:0] ch, input logic [11:0] rx, input logic [11:0] tx);
      mk = {ch[6:0], rx[2:0], rx[5:4], tx[3:0], tx[5:4], tx[6], sy, rx};
   endfunction
   // Cycles from a path request to ready; bounded so a hang ends the run
   task automatic ready_time(input logic tx);
      n = 0;
      cal = 1'b0;
      while ((tx ? tx_path_ready : rx_path_ready) !== 1'b1) begin
         cyc(1);
         n++;
         cal = cal | tx_offset_cal;
         if (n > 200) begin
            err_total++;
            tally_and_finish();
         end
      end
   endtask
   // Watchdog against a stuck sequence
   initial begin
      #1ms;
      err_total++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      samples_checked = 0;
      reset_n = 1'b0;
      logic_supply_rst_n = 1'b0;
      dflt = mk(12'h040, 12'h025, 12'hfd2, 12'h02d);
      cyc(20);
      reset_n = 1'b1;
      logic_supply_rst_n = 1'b1;
      cyc(6);
      chk(settings, dflt);
      chk(block_enables, 9'h00f);
      chk(op_mode, rmcsr_pkg::RMCSR_STANDBY);
      $display("test defaults done");
      wr(4'h2, 12'h041);
      wr(4'h3, 12'h063);
      wr(4'h4, 12'hfd5);
      wr(4'h5, 12'h07f);
      wr(4'h0, 12'hfff);
      wr(4'h6, 12'hfff);
      wr(4'hf, 12'h000);
      chk(settings, mk(12'h041, 12'h063, 12'hfd5, 12'h07f));
      u_rmcsr_ctrl_model.send_bits({12'h000, 4'h2, 16'h3000}, 20);
      cyc(8);
      chk(settings, mk(12'h041, 12'h000, 12'hfd5, 12'h07f));
      $display("test serial writes done");
      wr(4'h1, 12'h000);
      chk(block_enables, 9'h000);
      u_rmcsr_ctrl_model.set_pins(1'b1, 1'b0, 1'b1);
      ready_time(1'b0);
      chk(n >= RXC && n <= RXC + 6, 1'b1);
      chk(block_enables, 9'h038);
      mode(1'b1, 1'b0, 1'b0);
      u_rmcsr_ctrl_model.set_pins(1'b1, 1'b1, 1'b0);
      ready_time(1'b1);
      chk({cal, n >= TXC && n <= TXC + 6}, 2'h3);
      chk(block_enables, 9'h1c8);
      mode(1'b1, 1'b0, 1'b0);
      wr(4'h1, 12'h77e);
      chk(block_enables, 9'h1ff);
      $display("test block enables done");
      mode(1'b0, 1'b1, 1'b0);
      chk({op_mode, block_enables}, 12'h000);
      wr(4'h3, 12'h00a);
      mode(1'b1, 1'b0, 1'b0);
      chk({settings.channel_number, block_enables}, 16'h15ff);
      $display("test shutdown done");
      u_rmcsr_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
      logic_supply_rst_n = 1'b0;
      cyc(2);
      logic_supply_rst_n = 1'b1;
      cyc(6);
      chk(settings, dflt);
      chk(block_enables, 9'h00f);
      $display("test supply reload done");
      tally_and_finish();
   end
endmodule
